/* File: common/srb_pkg.sv */
// package: constants, carriers and states of the serial receive buffer channel
package srb_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BAUD_RATE = 9600;
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD_RATE;
    localparam logic [11:0] BIT_CNT_LAST = 12'(BIT_CYC - 1);
    localparam logic [11:0] HALF_CNT_LAST = 12'(BIT_CYC / 2 - 1);
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [15:0] OFS_CTRL_A = 16'h0000;
    localparam logic [15:0] OFS_CTRL_B = 16'h0002;
    localparam logic [15:0] OFS_STATUS = 16'h0004;
    localparam logic [15:0] OFS_TX_HOLD = 16'h0006;
    localparam logic [15:0] OFS_BUF_ACCESS = 16'hff00;
    localparam logic [15:0] OFS_BUF_PRESENCE = 16'hff80;
    // ----------------------------------------
    // fields and reset values
    // ----------------------------------------
    localparam int unsigned TE_BIT = 5;
    localparam int unsigned RTS_BIT = 4;
    localparam int unsigned ERR_CLR_BIT = 3;
    localparam int unsigned CTS_N_BIT = 5;
    localparam int unsigned RDRF_BIT = 7;
    localparam int unsigned OVRN_BIT = 6;
    localparam int unsigned DCD_BIT = 2;
    localparam int unsigned TRANSMIT_HOLDING_EMPTY_FLAG_BIT = 1;
    localparam logic [7:0] CTRL_A_RST = 8'h10;
    localparam logic [7:0] CTRL_B_RST = 8'h0f;
    localparam logic [7:0] PRESENCE_VAL = 8'h55;
    // ----------------------------------------
    // buffer and flow control
    // ----------------------------------------
    localparam int unsigned BUF_DEPTH = 128;
    localparam logic [7:0] BUF_FULL = 8'd128;
    localparam logic [7:0] PAUSE_LEVEL = 8'd118;
    localparam logic [7:0] RESUME_LEVEL = 8'd108;
    localparam logic [7:0] PAUSE_CHAR = 8'h13;
    localparam logic [7:0] RESUME_CHAR = 8'h11;
    localparam int unsigned FIFO_DEPTH = 8;
    // ----------------------------------------
    // carriers and states
    // ----------------------------------------
    typedef struct packed {
        logic io;
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } srb_cpu_req_type;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b10,
        TX_STOP = 2'b11
    } srb_tx_state_type;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } srb_rx_state_type;
endpackage : srb_pkg

/* File: hw/srb_fifo.sv */
// module: small valid/ready fifo with parameter width and depth
module srb_fifo
    import srb_pkg::*;
#(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = FIFO_DEPTH
)(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    wire logic full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
    wire logic empty = (wr_ptr_ff == rd_ptr_ff);
    wire logic push = in_valid_i && !full;
    wire logic pop = out_ready_i && !empty;

    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_ff[rd_ptr_ff[AW-1:0]];

    always_ff @(posedge sys_clk_i)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
            rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
        end
    end
endmodule : srb_fifo

/* File: hw/srb_rx.sv */
// module: receive line synchroniser and byte deserialiser
module srb_rx
    import srb_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // line
    input wire logic rxd_i,
    // byte out
    output logic [7:0] data_o,
    output logic valid_o
);
    logic s1_ff, s2_ff, s3_ff, lvl_ff;
    srb_rx_state_type st_ff, nxt_st;
    logic [11:0] cnt_ff, nxt_cnt;
    logic [2:0] bit_ff;
    logic [7:0] sh_ff;
    logic valid_ff;
    wire logic tick = (cnt_ff == 12'h000);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_cnt = tick ? BIT_CNT_LAST : cnt_ff - 12'h001;
        case (st_ff)
            RX_IDLE:
            begin
                nxt_cnt = HALF_CNT_LAST;
                if (!lvl_ff) nxt_st = RX_START;
            end
            RX_START: if (tick) nxt_st = lvl_ff ? RX_IDLE : RX_DATA;
            RX_DATA: if (tick && bit_ff == 3'h7) nxt_st = RX_STOP;
            RX_STOP: if (tick) nxt_st = RX_IDLE;
            default: nxt_st = RX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            {s1_ff, s2_ff, s3_ff, lvl_ff} <= 4'hf;
            st_ff <= RX_IDLE;
            cnt_ff <= 12'h000;
            bit_ff <= 3'h0;
            sh_ff <= 8'h00;
            valid_ff <= 1'b0;
        end
        else
        begin
            s1_ff <= rxd_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) lvl_ff <= s3_ff;
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            if (st_ff == RX_DATA && tick)
            begin
                sh_ff <= {lvl_ff, sh_ff[7:1]};
                bit_ff <= bit_ff + 3'h1;
            end
            valid_ff <= (st_ff == RX_STOP) && tick && lvl_ff;
        end
    end

    assign data_o = sh_ff;
    assign valid_o = valid_ff;
endmodule : srb_rx

/* File: hw/srb_channel.sv */
// module: secondary serial channel with shift-down receive buffer and flow control
//
// Function
// [RULE1] presence byte reads 0x55 while any byte is buffered, zero when empty
// [RULE2] access location always reads the oldest buffered byte
// [RULE3] advance pulse moves every remaining byte one place toward the access location
// [RULE4] software flow: send one pause character when fill reaches capacity minus ten
// [RULE5] keep accepting up to ten more bytes; drop bytes while buffer is full
// [RULE6] software flow: on advance, send resume character once twenty entries are free
// [RULE7] hardware flow: drive ready-to-send low when fill reaches capacity minus ten
// [RULE8] hardware flow: drive ready-to-send high again once twenty entries are free
// [RULE9] nothing is transmitted while the transmit enable bit is zero
// [RULE10] holding-empty flag reads one when the holding register is empty
// [RULE11] holding-empty flag drops to zero while a byte moves into the shifter
// [RULE12] control b bit 5 shows the inverted clear-to-send input
// [RULE13] clear-to-send low holds the empty flag at zero and halts sending
// [RULE14] a write to the holding register sends that byte on the line
// [RULE15] receive buffer holds 128 bytes, filled as bytes arrive
// [RULE16] a new byte lands in the lowest free position, behind older bytes
module srb_channel
    import srb_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // processor access
    input wire srb_cpu_req_type cpu_req_i,
    output logic [7:0] cpu_rdata_o,
    input wire logic buf_advance_i,
    input wire logic flow_hw_sel_i,
    // serial line
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic clear_to_send_input_ch0_i,
    input wire logic carrier_detect_input_ch0_i,
    output logic rts_o
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic logic hit(input srb_cpu_req_type r, input logic io, input logic [15:0] ofs);
        hit = (r.io == io) && (r.addr == ofs);
    endfunction : hit

    wire logic wr_ctrl_a = cpu_req_i.wr && hit(cpu_req_i, 1'b1, OFS_CTRL_A);
    wire logic wr_ctrl_b = cpu_req_i.wr && hit(cpu_req_i, 1'b1, OFS_CTRL_B);
    wire logic wr_hold = cpu_req_i.wr && hit(cpu_req_i, 1'b1, OFS_TX_HOLD);
    wire logic rd_any = cpu_req_i.rd;

    // ----------------------------------------
    // registers and state
    // ----------------------------------------
    logic [7:0] ctrl_a_ff;
    logic [7:0] ctrl_b_ff;
    logic ovrn_ff;
    logic [7:0] rdata_ff;
    logic rts_ff;
    logic [2:0] cts_s_ff;
    logic cts_lvl_ff;
    logic [2:0] dcd_s_ff;
    logic dcd_lvl_ff;
    logic [7:0] buf_mem [BUF_DEPTH];
    logic [7:0] count_ff, nxt_count;
    logic paused_ff;
    logic xoff_req_ff;
    logic xon_req_ff;
    logic [7:0] hold_ff;
    logic hold_full_ff;
    srb_tx_state_type tx_st_ff, nxt_tx_st;
    logic [11:0] tx_cnt_ff;
    logic [2:0] tx_bit_ff;
    logic [7:0] tx_sh_ff;
    logic txd_ff, nxt_txd;

    // ----------------------------------------
    // receive path
    // ----------------------------------------
    logic [7:0] rx_data;
    logic rx_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;

    srb_rx u_rx (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .rxd_i(rxd_i),
        .data_o(rx_data),
        .valid_o(rx_valid)
    );

    // drain stalls while the buffer is shifting
    srb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(rx_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(rx_data),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(!buf_advance_i),
        .out_data_o(fifo_out_data)
    );

    wire logic take = fifo_out_valid && !buf_advance_i;
    wire logic full = (count_ff == BUF_FULL);
    wire logic store = take && !full; // [RULE5]
    wire logic advance = buf_advance_i && (count_ff != 8'h00);
    wire logic sw_flow = !flow_hw_sel_i;

    assign nxt_count = count_ff + 8'(store) - 8'(advance);

    // ----------------------------------------
    // shift-down buffer
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < BUF_DEPTH; gi++)
        begin : g_ent
            wire logic [7:0] upper = (gi == BUF_DEPTH - 1) ? 8'h00 : buf_mem[(gi + 1) % BUF_DEPTH];
            always_ff @(posedge sys_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    buf_mem[gi] <= 8'h00;
                else if (advance)
                    buf_mem[gi] <= upper; // [RULE3]
                else if (store && count_ff == 8'(gi))
                    buf_mem[gi] <= fifo_out_data; // [RULE15] [RULE16]
            end
        end
    endgenerate

    // ----------------------------------------
    // fill level and flow control
    // ----------------------------------------
    wire logic hit_pause = store && !paused_ff && nxt_count >= PAUSE_LEVEL;
    wire logic hit_resume = advance && paused_ff && nxt_count <= RESUME_LEVEL;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            count_ff <= 8'h00;
            paused_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            if (hit_pause)
                paused_ff <= 1'b1; // [RULE4] [RULE7]
            else if (hit_resume)
                paused_ff <= 1'b0; // [RULE6] [RULE8]
        end
    end

    // ----------------------------------------
    // pin synchronisers and line outputs
    // ----------------------------------------
    wire logic cts_ok = cts_lvl_ff;

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cts_s_ff <= 3'h0;
            cts_lvl_ff <= 1'b0;
            dcd_s_ff <= 3'h0;
            dcd_lvl_ff <= 1'b0;
            rts_ff <= 1'b0;
        end
        else
        begin
            cts_s_ff <= {cts_s_ff[1:0], clear_to_send_input_ch0_i};
            if (cts_s_ff[1] == cts_s_ff[2]) cts_lvl_ff <= cts_s_ff[2];
            dcd_s_ff <= {dcd_s_ff[1:0], carrier_detect_input_ch0_i};
            if (dcd_s_ff[1] == dcd_s_ff[2]) dcd_lvl_ff <= dcd_s_ff[2];
            rts_ff <= flow_hw_sel_i ? !paused_ff : !ctrl_a_ff[RTS_BIT]; // [RULE7] [RULE8]
        end
    end

    assign rts_o = rts_ff;
    assign txd_o = txd_ff;

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    wire logic tx_go = (tx_st_ff == TX_IDLE) && ctrl_a_ff[TE_BIT] && cts_ok; // [RULE9] [RULE13]
    wire logic flow_pend = xoff_req_ff || xon_req_ff;
    wire logic load_flow = tx_go && flow_pend;
    wire logic load_hold = tx_go && !flow_pend && hold_full_ff; // [RULE14]
    wire logic transmit_holding_empty_flag = !hold_full_ff && !load_hold && cts_ok; // [RULE10] [RULE11] [RULE13]
    wire logic tx_tick = (tx_cnt_ff == 12'h000);
    wire logic [7:0] load_byte = xoff_req_ff ? PAUSE_CHAR : (xon_req_ff ? RESUME_CHAR : hold_ff);

    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        nxt_txd = txd_ff;
        case (tx_st_ff)
            TX_IDLE:
            begin
                if (load_flow || load_hold)
                begin
                    nxt_tx_st = TX_START;
                    nxt_txd = 1'b0;
                end
            end
            TX_START:
            begin
                if (tx_tick)
                begin
                    nxt_tx_st = TX_DATA;
                    nxt_txd = tx_sh_ff[0];
                end
            end
            TX_DATA:
            begin
                if (tx_tick && tx_bit_ff == 3'h7)
                begin
                    nxt_tx_st = TX_STOP;
                    nxt_txd = 1'b1;
                end
                else if (tx_tick)
                    nxt_txd = tx_sh_ff[1];
            end
            TX_STOP: if (tx_tick) nxt_tx_st = TX_IDLE;
            default:
            begin
                nxt_tx_st = TX_IDLE;
                nxt_txd = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tx_st_ff <= TX_IDLE;
            tx_cnt_ff <= 12'h000;
            tx_bit_ff <= 3'h0;
            tx_sh_ff <= 8'h00;
            txd_ff <= 1'b1;
        end
        else
        begin
            tx_st_ff <= nxt_tx_st;
            txd_ff <= nxt_txd;
            tx_cnt_ff <= (tx_st_ff == TX_IDLE || tx_tick) ? BIT_CNT_LAST : tx_cnt_ff - 12'h001;
            if (tx_st_ff == TX_IDLE)
            begin
                tx_sh_ff <= load_byte;
                tx_bit_ff <= 3'h0;
            end
            else if (tx_st_ff == TX_DATA && tx_tick)
            begin
                tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
                tx_bit_ff <= tx_bit_ff + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    wire logic [7:0] stat_val = {count_ff != 8'h00, ovrn_ff, 3'h0, dcd_lvl_ff, transmit_holding_empty_flag, 1'b0};
    wire logic [7:0] ctrl_b_val = {ctrl_b_ff[7:6], !cts_ok, ctrl_b_ff[4:0]}; // [RULE12] [RULE13]
    wire logic [7:0] pres_val = (count_ff != 8'h00) ? PRESENCE_VAL : 8'h00; // [RULE1]
    wire logic [7:0] rd_val =
        hit(cpu_req_i, 1'b1, OFS_CTRL_A) ? ctrl_a_ff :
        hit(cpu_req_i, 1'b1, OFS_CTRL_B) ? ctrl_b_val :
        hit(cpu_req_i, 1'b1, OFS_STATUS) ? stat_val :
        hit(cpu_req_i, 1'b0, OFS_BUF_ACCESS) ? buf_mem[0] : // [RULE2]
        hit(cpu_req_i, 1'b0, OFS_BUF_PRESENCE) ? pres_val : 8'h00;
    wire logic ovrn_set = rx_valid && !fifo_in_ready;
    wire logic ovrn_clr = wr_ctrl_a && !cpu_req_i.wdata[ERR_CLR_BIT];

    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_a_ff <= CTRL_A_RST;
            ctrl_b_ff <= CTRL_B_RST;
            ovrn_ff <= 1'b0;
            rdata_ff <= 8'h00;
            hold_ff <= 8'h00;
            hold_full_ff <= 1'b0;
            xoff_req_ff <= 1'b0;
            xon_req_ff <= 1'b0;
        end
        else
        begin
            if (wr_ctrl_a) ctrl_a_ff <= cpu_req_i.wdata;
            if (wr_ctrl_b) ctrl_b_ff <= cpu_req_i.wdata;
            ovrn_ff <= ovrn_set || (ovrn_ff && !ovrn_clr);
            if (rd_any) rdata_ff <= rd_val;
            if (wr_hold) hold_ff <= cpu_req_i.wdata;
            hold_full_ff <= wr_hold || (hold_full_ff && !load_hold); // [RULE14]
            xoff_req_ff <= (hit_pause && sw_flow) || (xoff_req_ff && !load_flow); // [RULE4]
            xon_req_ff <= (hit_resume && sw_flow) || (xon_req_ff && !(load_flow && !xoff_req_ff)); // [RULE6]
        end
    end

    assign cpu_rdata_o = rdata_ff;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    wire logic rd_pres = rd_any && hit(cpu_req_i, 1'b0, OFS_BUF_PRESENCE);
    wire logic rd_acc = rd_any && hit(cpu_req_i, 1'b0, OFS_BUF_ACCESS);
    wire logic rd_cb = rd_any && hit(cpu_req_i, 1'b1, OFS_CTRL_B);

    property p_presence;
        rd_pres |=> cpu_rdata_o == (($past(count_ff) != 8'h00) ? PRESENCE_VAL : 8'h00);
    endproperty
    a_presence: assert property (p_presence) else $error("presence byte wrong"); // [RULE1]
    property p_access;
        rd_acc |=> cpu_rdata_o == $past(buf_mem[0]);
    endproperty
    a_access: assert property (p_access) else $error("access location not oldest"); // [RULE2]
    property p_shift;
        advance && count_ff > 8'h01 |=> buf_mem[0] == $past(buf_mem[1]) && count_ff == $past(count_ff) - 8'h01;
    endproperty
    a_shift: assert property (p_shift) else $error("shift down failed"); // [RULE3]
    property p_pause;
        sw_flow && store && !paused_ff && count_ff == PAUSE_LEVEL - 8'h01 |=> xoff_req_ff && paused_ff;
    endproperty
    a_pause: assert property (p_pause) else $error("pause char not requested"); // [RULE4]
    property p_drop;
        full && !buf_advance_i |=> count_ff == BUF_FULL;
    endproperty
    a_drop: assert property (p_drop) else $error("full buffer changed"); // [RULE5]
    property p_resume;
        sw_flow && paused_ff && advance && count_ff == RESUME_LEVEL + 8'h01 |=> xon_req_ff && !paused_ff;
    endproperty
    a_resume: assert property (p_resume) else $error("resume char not requested"); // [RULE6]
    property p_rts_low;
        flow_hw_sel_i && paused_ff |=> !rts_o;
    endproperty
    a_rts_low: assert property (p_rts_low) else $error("rts not low"); // [RULE7]
    property p_rts_high;
        flow_hw_sel_i && !paused_ff |=> rts_o;
    endproperty
    a_rts_high: assert property (p_rts_high) else $error("rts not high"); // [RULE8]
    property p_te;
        tx_st_ff == TX_IDLE && !ctrl_a_ff[TE_BIT] |=> tx_st_ff == TX_IDLE && txd_o;
    endproperty
    a_te: assert property (p_te) else $error("sent while disabled"); // [RULE9]
    property p_transmit_holding_empty_flag;
        hold_full_ff |-> !transmit_holding_empty_flag;
    endproperty
    a_transmit_holding_empty_flag: assert property (p_transmit_holding_empty_flag) else $error("empty flag set while full"); // [RULE10]
    property p_move;
        load_hold |-> !transmit_holding_empty_flag ##1 (tx_st_ff == TX_START && !hold_full_ff);
    endproperty
    a_move: assert property (p_move) else $error("move into shifter wrong"); // [RULE11]
    property p_cts_bit;
        rd_cb |=> cpu_rdata_o[CTS_N_BIT] == !$past(cts_ok);
    endproperty
    a_cts_bit: assert property (p_cts_bit) else $error("cts bit not inverted"); // [RULE12]
    property p_cts_halt;
        !cts_ok |-> !transmit_holding_empty_flag && !load_hold && !load_flow;
    endproperty
    a_cts_halt: assert property (p_cts_halt) else $error("cts low did not halt"); // [RULE13]
    property p_start;
        load_hold |=> !txd_o && tx_sh_ff == $past(hold_ff);
    endproperty
    a_start: assert property (p_start) else $error("start bit missing"); // [RULE14]
    property p_store;
        store |=> buf_mem[$past(count_ff[6:0])] == $past(fifo_out_data);
    endproperty
    a_store: assert property (p_store) else $error("byte not at lowest free"); // [RULE15] [RULE16]

    c_pause: cover property (load_flow && xoff_req_ff);
    c_resume: cover property (load_flow && !xoff_req_ff && xon_req_ff);
    c_drop: cover property (take && full);
    c_send: cover property (load_hold);
endmodule : srb_channel

/* File: tb/srb_term.sv */
// partner: terminal model that sends and receives 8N1 characters
module srb_term
    import srb_pkg::*;
(
    // clock
    input wire logic sys_clk_i,
    // line
    input wire logic txd_i,
    output logic rxd_o,
    output logic cts_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // line driver and sampler
    // ----------------------------------------
    initial
    begin
        rxd_o = 1'b1;
        cts_o = 1'b1;
    end
    task automatic set_cts(input logic level);
        @(posedge sys_clk_i);
        cts_o <= level;
    endtask : set_cts
    task automatic send_byte(input logic [7:0] value);
        logic [9:0] frame;
        frame = {1'b1, value, 1'b0};
        @(posedge sys_clk_i);
        for (int i = 0; i < 10; i++)
        begin
            rxd_o <= frame[i];
            repeat (BIT_CYC) @(posedge sys_clk_i);
        end
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] value, output logic timed_out);
        int n;
        n = 0;
        value = 8'h00;
        while (txd_i !== 1'b0 && n < 5000)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        timed_out = (n >= 5000);
        // sample each bit near its middle
        repeat (BIT_CYC / 2) @(posedge sys_clk_i);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(posedge sys_clk_i);
            value[i] = txd_i;
        end
    endtask : recv_byte
endmodule : srb_term

/* File: tb/test_serial_rx_buffer_flow_ctrl.sv */
// bench: register access, receive buffer and transmit scenarios of the serial channel
module test_serial_rx_buffer_flow_ctrl
    import srb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    srb_cpu_req_type cpu_req = '0;
    logic [7:0] cpu_rdata;
    logic buf_advance = 1'b0;
    logic dcd = 1'b0;
    logic flow_hw = 1'b0;
    logic rxd, txd, cts, rts;
    int n_errors = 0;
    int checks_done = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    srb_channel i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .cpu_req_i(cpu_req), .cpu_rdata_o(cpu_rdata),
        .buf_advance_i(buf_advance), .flow_hw_sel_i(flow_hw), .rxd_i(rxd), .txd_o(txd),
        .clear_to_send_input_ch0_i(cts), .carrier_detect_input_ch0_i(dcd), .rts_o(rts));
    srb_term i_term (.sys_clk_i(sys_clk_i), .txd_i(txd), .rxd_o(rxd), .cts_o(cts));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus_cycle(input logic io, input logic [15:0] addr, input logic wr, input logic [7:0] wdata);
        @(posedge sys_clk_i);
        cpu_req <= '{io: io, addr: addr, wr: wr, rd: !wr, wdata: wdata};
        @(posedge sys_clk_i);
        cpu_req <= '0;
        #1;
    endtask : bus_cycle
    task automatic rd_chk(input logic io, input logic [15:0] addr, input logic [7:0] exp);
        bus_cycle(io, addr, 1'b0, 8'h00);
        check(cpu_rdata, exp);
    endtask : rd_chk
    task automatic advance;
        @(posedge sys_clk_i);
        buf_advance <= 1'b1;
        @(posedge sys_clk_i);
        buf_advance <= 1'b0;
        #1;
    endtask : advance
    task automatic recv_chk(input logic [7:0] exp);
        logic [7:0] got;
        logic to;
        i_term.recv_byte(got, to);
        if (to)
        begin
            n_errors++;
            print_verdict;
        end
        else
            check(got, exp);
    endtask : recv_chk
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        // let the clear-to-send synchroniser settle
        repeat (4) @(posedge sys_clk_i);
        rd_chk(1'b0, OFS_BUF_PRESENCE, 8'h00);
        rd_chk(1'b1, OFS_CTRL_A, CTRL_A_RST);
        rd_chk(1'b1, OFS_CTRL_B, CTRL_B_RST);
        rd_chk(1'b1, OFS_STATUS, 8'h02);
        rd_chk(1'b1, 16'h0010, 8'h00);
        fork
            begin
                i_term.send_byte(8'ha5);
                i_term.send_byte(8'h3c);
            end
            begin
                bus_cycle(1'b1, OFS_TX_HOLD, 1'b1, 8'h5a);
                rd_chk(1'b1, OFS_STATUS, 8'h00);
                repeat (50) @(posedge sys_clk_i);
                check({7'h00, txd}, 8'h01);
                bus_cycle(1'b1, OFS_CTRL_A, 1'b1, 8'h30);
                rd_chk(1'b1, OFS_STATUS, 8'h02);
                recv_chk(8'h5a);
            end
        join
        rd_chk(1'b0, OFS_BUF_PRESENCE, PRESENCE_VAL);
        rd_chk(1'b0, OFS_BUF_ACCESS, 8'ha5);
        advance();
        rd_chk(1'b0, OFS_BUF_ACCESS, 8'h3c);
        rd_chk(1'b0, OFS_BUF_PRESENCE, PRESENCE_VAL);
        advance();
        rd_chk(1'b0, OFS_BUF_PRESENCE, 8'h00);
        rd_chk(1'b1, OFS_STATUS, 8'h02);
        // sending off: the holding byte is loaded only while clear-to-send is high
        bus_cycle(1'b1, OFS_CTRL_A, 1'b1, 8'h10);
        i_term.set_cts(1'b0);
        repeat (4) @(posedge sys_clk_i);
        rd_chk(1'b1, OFS_CTRL_B, 8'h2f);
        rd_chk(1'b1, OFS_STATUS, 8'h00);
        i_term.set_cts(1'b1);
        repeat (4) @(posedge sys_clk_i);
        rd_chk(1'b1, OFS_STATUS, 8'h02);
        bus_cycle(1'b1, OFS_TX_HOLD, 1'b1, 8'hc3);
        i_term.set_cts(1'b0);
        repeat (4) @(posedge sys_clk_i);
        bus_cycle(1'b1, OFS_CTRL_A, 1'b1, 8'h30);
        repeat (100) @(posedge sys_clk_i);
        check({7'h00, txd}, 8'h01);
        i_term.set_cts(1'b1);
        recv_chk(8'hc3);
        // character flow: ready-to-send is the inverse of control a bit 4, which is set
        check({7'h00, rts}, 8'h00);
        @(posedge sys_clk_i);
        flow_hw <= 1'b1;
        dcd <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1;
        check({7'h00, rts}, 8'h01);
        rd_chk(1'b1, OFS_STATUS, 8'h06);
        print_verdict();
    end
endmodule : test_serial_rx_buffer_flow_ctrl
